// [logic/pio_pkg.sv]
// constants, register map and types shared by the parallel port block
package pio_pkg;
  // ============================================================
  // bus and register indices (byte address = index * 4)
  // ============================================================
  localparam int ADDR_W = 16;
  localparam int IDX_W = 14;
  localparam logic [IDX_W-1:0] IDX_TIMER_PORT = 14'h1000;
  localparam logic [IDX_W-1:0] IDX_PARALLEL_CONTROL = 14'h1002;
  localparam logic [IDX_W-1:0] IDX_ADDR_DATA_PORT = 14'h1003;
  localparam logic [IDX_W-1:0] IDX_HIGH_ADDR_PORT = 14'h1004;
  localparam logic [IDX_W-1:0] IDX_STROBE_LATCH = 14'h1005;
  localparam logic [IDX_W-1:0] IDX_BUS_PORT_DIR = 14'h1007;
  localparam logic [IDX_W-1:0] IDX_SERIAL_PORT = 14'h1008;
  localparam logic [IDX_W-1:0] IDX_SERIAL_PORT_DIR = 14'h1009;
  localparam logic [IDX_W-1:0] IDX_PULSE_ACCUM_CTRL = 14'h1026;
  localparam logic [IDX_W-1:0] IDX_MODE_STATUS = 14'h1040;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ============================================================
  // port widths and line masks
  // ============================================================
  localparam int PORT_W = 8;
  localparam int SERIAL_W = 6;
  localparam int TOTAL_LINES = 38;
  localparam logic [7:0] TIMER_OUT_ONLY_MASK = 8'h70;
  localparam int LINE7 = 7;
  localparam int LINE3 = 3;
  localparam int LINE5 = 5;
  // ============================================================
  // field positions
  // ============================================================
  localparam int PAC_LINE7_DIR_BIT = 7;
  localparam int PAC_LINE3_DIR_BIT = 3;
  localparam int PC_STROBE_A_FLAG_BIT = 7;
  localparam int PC_CWOM_BIT = 5;
  localparam int PC_HNDS_BIT = 4;
  localparam int PC_OIN_BIT = 3;
  localparam int PC_EGA_BIT = 1;
  localparam logic [7:0] PC_WRITE_MASK = 8'h7F;
  // ============================================================
  // reset values
  // ============================================================
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] HIGH_ADDR_PORT_RESET = 8'h00;
  localparam logic [7:0] PULSE_ACCUM_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] PARALLEL_CONTROL_RESET = 8'h00;
  // ============================================================
  // operating modes, strap code is {modb, moda}
  // ============================================================
  localparam logic [1:0] STRAP_BOOT = 2'h0;
  localparam logic [1:0] STRAP_TEST = 2'h1;
  localparam logic [1:0] STRAP_SINGLE = 2'h2;
  localparam logic [1:0] STRAP_EXPANDED = 2'h3;
  typedef enum logic [3:0] {
    PIO_MODE_SINGLE = 4'h1,
    PIO_MODE_EXPANDED = 4'h2,
    PIO_MODE_BOOT = 4'h4,
    PIO_MODE_TEST = 4'h8
  } pio_mode_e;
endpackage

// [logic/pio_pin_if.sv]
// carrier between the port core and one bank of pin drivers
`timescale 1ns/1ps
interface pio_pin_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic [W-1:0] drive;
  logic [W-1:0] open_drain;
  logic [W-1:0] level;
  modport core (output data, output drive, output open_drain, input level);
  modport pins (input data, input drive, input open_drain, output level);
endinterface

// [logic/pio_pins.sv]
// registered pin driver bank with optional open-drain output
`timescale 1ns/1ps
module pio_pins #(parameter int W = 8) (
  input wire logic mclk_in,
  input wire logic reset_in,
  pio_pin_if.pins bank,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_out
);
  logic [W-1:0] out_reg;
  logic [W-1:0] oe_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] oe_next;

  // open-drain lines only ever pull low
  assign oe_next = bank.drive & ~(bank.open_drain & bank.data);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      out_reg <= '0;
      oe_reg <= '0;
      level_reg <= '0;
    end else begin
      out_reg <= bank.data & ~bank.open_drain;
      oe_reg <= oe_next;
      level_reg <= pin_in;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe_out = oe_reg;
  assign bank.level = level_reg;
endmodule

// [logic/pio_edge.sv]
// edge detector with selectable active edge
`timescale 1ns/1ps
module pio_edge (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic sig_in,
  input wire logic rising_sel_in,
  output logic edge_out
);
  logic prev_reg;
  logic rise;
  logic fall;

  assign rise = sig_in & ~prev_reg;
  assign fall = ~sig_in & prev_reg;
  assign edge_out = rising_sel_in ? rise : fall;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sig_in;
    end
  end
endmodule

// [logic/pio_ports.sv]
// parallel ports a to d with their register file on an axi4-lite slave
//
// Overview of operation
// - five ports with up to 38 lines total, usable count depends on mode; this block has ports a to d only, 30 lines
// - port a: three input-only, three output-only, two bidirectional timer lines
// - line 7 direction bit 0 input 1 output; output compare overrides it
// - line 7 always feeds the pulse accumulator input, even as output
// - line 3 direction bit 0 input 1 output; output compare overrides it
// - port b is general output in single-chip/bootstrap, high address otherwise
// - port c directions clear at reset so lines start as inputs
// - expanded/test: port c carries address/data; its register goes external
// - each active strobe a edge captures port c pins into the latch, except under output handshake
// - latch read returns last capture; after armed control read, a latch read (write under output handshake) clears flag
// - port c direction 0 input 1 output; output handshake selects three-state
// - port d lines 5..0 serve general i/o or serial and spi
// - reset clears port d directions so lines 5..0 become inputs
// - data of high-impedance inputs is indeterminate after reset
// - line 5 output with spi master: general output, mode fault disabled
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pio_ports (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [1:0] mode_strap_in,
  // axi4-lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [15:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // port a and timer
  input wire logic [7:0] timer_port_in,
  output logic [7:0] timer_port_out,
  output logic [7:0] timer_port_oe_out,
  input wire logic [4:0] compare_force_in,
  input wire logic [4:0] compare_level_in,
  output logic pulse_accum_input_out,
  output logic [3:0] capture_out,
  // port b and external bus
  input wire logic [7:0] ext_addr_high_in,
  output logic [7:0] high_address_port_out,
  output logic [7:0] high_address_port_oe_out,
  // port c
  input wire logic [7:0] address_data_port_in,
  output logic [7:0] address_data_port_out,
  output logic [7:0] address_data_port_oe_out,
  input wire logic [7:0] ext_addr_data_in,
  input wire logic ext_addr_data_drive_in,
  input wire logic strobe_input_a_in,
  // port d and serial subsystems
  input wire logic [5:0] serial_port_in,
  output logic [5:0] serial_port_out,
  output logic [5:0] serial_port_oe_out,
  input wire logic [5:0] alt_enable_in,
  input wire logic [5:0] alt_level_in,
  input wire logic [5:0] alt_drive_in,
  input wire logic spi_master_select_in,
  output logic [5:0] serial_pin_level_out,
  output logic mode_fault_disable_out
);
  // ============================================================
  // state
  // ============================================================
  pio_pkg::pio_mode_e mode_reg;
  logic [7:0] timer_port_data_reg;
  logic [7:0] high_address_port_data_reg;
  logic [7:0] address_data_port_data_reg;
  logic [7:0] strobe_latched_input_reg;
  logic [7:0] bus_port_direction_reg;
  logic [5:0] serial_port_data_reg;
  logic [5:0] serial_port_direction_reg;
  logic [7:0] pulse_accum_control_reg;
  logic [6:0] parallel_control_reg;
  logic strobe_a_flag_reg;
  logic flag_armed_reg;
  logic mode_fault_disable_reg;
  logic awready_reg;
  logic wready_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [15:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [7:0] rdata_reg;
  logic [1:0] rresp_reg;

  pio_pin_if #(.W(pio_pkg::PORT_W)) bank_a ();
  pio_pin_if #(.W(pio_pkg::PORT_W)) bank_b ();
  pio_pin_if #(.W(pio_pkg::PORT_W)) bank_c ();
  pio_pin_if #(.W(pio_pkg::SERIAL_W)) bank_d ();

  // ============================================================
  // mode decode
  // ============================================================
  pio_pkg::pio_mode_e strap_mode;
  logic bus_mode;
  logic single_chip;
  assign strap_mode = (mode_strap_in == pio_pkg::STRAP_SINGLE) ? pio_pkg::PIO_MODE_SINGLE :
                      (mode_strap_in == pio_pkg::STRAP_EXPANDED) ? pio_pkg::PIO_MODE_EXPANDED :
                      (mode_strap_in == pio_pkg::STRAP_TEST) ? pio_pkg::PIO_MODE_TEST :
                      pio_pkg::PIO_MODE_BOOT;
  assign bus_mode = (mode_reg == pio_pkg::PIO_MODE_EXPANDED) || (mode_reg == pio_pkg::PIO_MODE_TEST);
  assign single_chip = (mode_reg == pio_pkg::PIO_MODE_SINGLE);

  // ============================================================
  // port a: timer lines
  // ============================================================
  logic [7:0] a_force;
  logic [7:0] a_bidir_drive;
  assign a_force = {compare_force_in, 3'h0};
  assign a_bidir_drive[pio_pkg::LINE7] = pulse_accum_control_reg[pio_pkg::PAC_LINE7_DIR_BIT] |
                                         compare_force_in[4];
  assign a_bidir_drive[pio_pkg::LINE3] = pulse_accum_control_reg[pio_pkg::PAC_LINE3_DIR_BIT] |
                                         compare_force_in[0];
  assign a_bidir_drive[6:4] = 3'h0;
  assign a_bidir_drive[2:0] = 3'h0;
  assign bank_a.drive = pio_pkg::TIMER_OUT_ONLY_MASK | a_bidir_drive;
  assign bank_a.data = (a_force & {compare_level_in, 3'h0}) | (~a_force & timer_port_data_reg);
  assign bank_a.open_drain = pio_pkg::BYTE_ZERO;
  assign pulse_accum_input_out = bank_a.level[pio_pkg::LINE7];
  assign capture_out = {bank_a.level[3], bank_a.level[0], bank_a.level[1], bank_a.level[2]};

  // ============================================================
  // port b: general outputs or high address
  // ============================================================
  assign bank_b.data = bus_mode ? ext_addr_high_in : high_address_port_data_reg;
  assign bank_b.drive = ~pio_pkg::BYTE_ZERO;
  assign bank_b.open_drain = pio_pkg::BYTE_ZERO;

  // ============================================================
  // port c: address/data bus or handshake port
  // ============================================================
  logic out_handshake;
  logic strobe_active_level;
  logic strobe_edge;
  logic [7:0] c_port_drive;
  assign out_handshake = parallel_control_reg[pio_pkg::PC_HNDS_BIT] & parallel_control_reg[pio_pkg::PC_OIN_BIT];
  assign strobe_active_level = strobe_input_a_in ^ parallel_control_reg[pio_pkg::PC_EGA_BIT];
  // output handshake: lines drive while strobe a is at its active level
  assign c_port_drive = (out_handshake && strobe_active_level) ? ~pio_pkg::BYTE_ZERO :
                        bus_port_direction_reg;
  assign bank_c.data = bus_mode ? ext_addr_data_in :
                       (out_handshake ? strobe_latched_input_reg : address_data_port_data_reg);
  assign bank_c.drive = bus_mode ? {8{ext_addr_data_drive_in}} : c_port_drive;
  assign bank_c.open_drain = (bus_mode || !parallel_control_reg[pio_pkg::PC_CWOM_BIT]) ?
                             pio_pkg::BYTE_ZERO : ~pio_pkg::BYTE_ZERO;

  pio_edge u_strobe_edge (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .sig_in(strobe_input_a_in),
    .rising_sel_in(parallel_control_reg[pio_pkg::PC_EGA_BIT]),
    .edge_out(strobe_edge)
  );

  // ============================================================
  // port d: serial and spi lines
  // ============================================================
  logic [5:0] d_alt;
  logic line5_general;
  assign line5_general = serial_port_direction_reg[pio_pkg::LINE5] & spi_master_select_in;
  assign d_alt = alt_enable_in & ~{line5_general, 5'h00};
  assign bank_d.data = (d_alt & alt_level_in) | (~d_alt & serial_port_data_reg);
  assign bank_d.drive = (d_alt & alt_drive_in) | (~d_alt & serial_port_direction_reg);
  assign bank_d.open_drain = 6'h00;
  assign serial_pin_level_out = bank_d.level;

  pio_pins #(.W(pio_pkg::PORT_W)) u_pins_a (
    .mclk_in(mclk_in), .reset_in(reset_in), .bank(bank_a),
    .pin_in(timer_port_in), .pin_out(timer_port_out), .pin_oe_out(timer_port_oe_out)
  );
  pio_pins #(.W(pio_pkg::PORT_W)) u_pins_b (
    .mclk_in(mclk_in), .reset_in(reset_in), .bank(bank_b),
    .pin_in(pio_pkg::BYTE_ZERO), .pin_out(high_address_port_out), .pin_oe_out(high_address_port_oe_out)
  );
  pio_pins #(.W(pio_pkg::PORT_W)) u_pins_c (
    .mclk_in(mclk_in), .reset_in(reset_in), .bank(bank_c),
    .pin_in(address_data_port_in), .pin_out(address_data_port_out), .pin_oe_out(address_data_port_oe_out)
  );
  pio_pins #(.W(pio_pkg::SERIAL_W)) u_pins_d (
    .mclk_in(mclk_in), .reset_in(reset_in), .bank(bank_d),
    .pin_in(serial_port_in), .pin_out(serial_port_out), .pin_oe_out(serial_port_oe_out)
  );

  // ============================================================
  // axi4-lite handshakes
  // ============================================================
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic rd_take;
  logic [pio_pkg::IDX_W-1:0] wr_idx;
  logic [pio_pkg::IDX_W-1:0] rd_idx;
  logic wr_en;
  assign aw_take = s_axi_awvalid & awready_reg;
  assign w_take = s_axi_wvalid & wready_reg;
  assign wr_do = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign rd_take = s_axi_arvalid & arready_reg;
  assign wr_idx = awaddr_reg[pio_pkg::ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[pio_pkg::ADDR_W-1:2];
  assign wr_en = wr_do & wstrb_reg;

  // ============================================================
  // address decode
  // ============================================================
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic wr_timer;
  logic wr_addr_data;
  logic wr_high_addr;
  logic wr_latch;
  logic wr_bus_dir;
  logic wr_serial;
  logic wr_serial_dir;
  logic wr_pulse_accum;
  logic wr_parallel;
  logic rd_latch;
  logic rd_parallel;
  assign wr_timer = wr_en && wr_idx == pio_pkg::IDX_TIMER_PORT;
  // port c register is external in bus modes
  assign wr_addr_data = wr_en && !bus_mode && wr_idx == pio_pkg::IDX_ADDR_DATA_PORT;
  assign wr_high_addr = wr_en && wr_idx == pio_pkg::IDX_HIGH_ADDR_PORT;
  assign wr_latch = wr_en && wr_idx == pio_pkg::IDX_STROBE_LATCH;
  assign wr_bus_dir = wr_en && wr_idx == pio_pkg::IDX_BUS_PORT_DIR;
  assign wr_serial = wr_en && wr_idx == pio_pkg::IDX_SERIAL_PORT;
  assign wr_serial_dir = wr_en && wr_idx == pio_pkg::IDX_SERIAL_PORT_DIR;
  assign wr_pulse_accum = wr_en && wr_idx == pio_pkg::IDX_PULSE_ACCUM_CTRL;
  assign wr_parallel = wr_en && wr_idx == pio_pkg::IDX_PARALLEL_CONTROL;
  assign rd_latch = rd_take && rd_idx == pio_pkg::IDX_STROBE_LATCH;
  assign rd_parallel = rd_take && rd_idx == pio_pkg::IDX_PARALLEL_CONTROL;
  assign wr_hit = (wr_idx == pio_pkg::IDX_TIMER_PORT) || (wr_idx == pio_pkg::IDX_ADDR_DATA_PORT) ||
                  (wr_idx == pio_pkg::IDX_HIGH_ADDR_PORT) || (wr_idx == pio_pkg::IDX_STROBE_LATCH) ||
                  (wr_idx == pio_pkg::IDX_BUS_PORT_DIR) || (wr_idx == pio_pkg::IDX_SERIAL_PORT) ||
                  (wr_idx == pio_pkg::IDX_SERIAL_PORT_DIR) || (wr_idx == pio_pkg::IDX_PULSE_ACCUM_CTRL) ||
                  (wr_idx == pio_pkg::IDX_PARALLEL_CONTROL) || (wr_idx == pio_pkg::IDX_MODE_STATUS);

  // ports a, c and d read back pin levels, so undriven inputs read whatever the pins show; port b reads its register
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = pio_pkg::BYTE_ZERO;
    case (rd_idx)
      pio_pkg::IDX_TIMER_PORT: rd_byte = bank_a.level;
      pio_pkg::IDX_ADDR_DATA_PORT: rd_byte = bank_c.level;
      pio_pkg::IDX_HIGH_ADDR_PORT: rd_byte = high_address_port_data_reg;
      pio_pkg::IDX_STROBE_LATCH: rd_byte = strobe_latched_input_reg;
      pio_pkg::IDX_BUS_PORT_DIR: rd_byte = bus_port_direction_reg;
      pio_pkg::IDX_SERIAL_PORT: rd_byte = {2'h0, bank_d.level};
      pio_pkg::IDX_SERIAL_PORT_DIR: rd_byte = {2'h0, serial_port_direction_reg};
      pio_pkg::IDX_PULSE_ACCUM_CTRL: rd_byte = pulse_accum_control_reg;
      pio_pkg::IDX_PARALLEL_CONTROL: rd_byte = {strobe_a_flag_reg, parallel_control_reg};
      pio_pkg::IDX_MODE_STATUS: rd_byte = {4'h0, mode_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // ============================================================
  // strobe a flag: set wins over the clearing sequence
  // ============================================================
  logic flag_clear;
  logic strobe_a_flag_next;
  logic flag_armed_next;
  assign flag_clear = flag_armed_reg & (out_handshake ? wr_latch : rd_latch);
  assign strobe_a_flag_next = (single_chip & strobe_edge) | (strobe_a_flag_reg & ~flag_clear);
  assign flag_armed_next = (rd_parallel & strobe_a_flag_reg) | (flag_armed_reg & ~flag_clear);

  // ============================================================
  // registers
  // ============================================================
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mode_reg <= strap_mode;
      timer_port_data_reg <= pio_pkg::BYTE_ZERO;
      high_address_port_data_reg <= pio_pkg::HIGH_ADDR_PORT_RESET;
      address_data_port_data_reg <= pio_pkg::BYTE_ZERO;
      strobe_latched_input_reg <= pio_pkg::BYTE_ZERO;
      bus_port_direction_reg <= pio_pkg::DIR_RESET;
      serial_port_data_reg <= 6'h00;
      serial_port_direction_reg <= 6'h00;
      pulse_accum_control_reg <= pio_pkg::PULSE_ACCUM_RESET;
      parallel_control_reg <= pio_pkg::PARALLEL_CONTROL_RESET[6:0];
      strobe_a_flag_reg <= 1'b0;
      flag_armed_reg <= 1'b0;
      mode_fault_disable_reg <= 1'b0;
    end else begin
      if (wr_timer) timer_port_data_reg <= wdata_reg;
      if (wr_high_addr) high_address_port_data_reg <= wdata_reg;
      if (wr_addr_data) address_data_port_data_reg <= wdata_reg;
      if (strobe_edge && !out_handshake) begin
        strobe_latched_input_reg <= bank_c.level;
      end else if (wr_latch) begin
        strobe_latched_input_reg <= wdata_reg;
      end
      if (wr_bus_dir) bus_port_direction_reg <= wdata_reg;
      if (wr_serial) serial_port_data_reg <= wdata_reg[5:0];
      if (wr_serial_dir) serial_port_direction_reg <= wdata_reg[5:0];
      if (wr_pulse_accum) pulse_accum_control_reg <= wdata_reg;
      if (wr_parallel) parallel_control_reg <= wdata_reg[6:0] & pio_pkg::PC_WRITE_MASK[6:0];
      strobe_a_flag_reg <= strobe_a_flag_next;
      flag_armed_reg <= flag_armed_next;
      mode_fault_disable_reg <= line5_general;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= pio_pkg::BYTE_ZERO;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= pio_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= pio_pkg::BYTE_ZERO;
      rresp_reg <= pio_pkg::RESP_OKAY;
    end else if (rd_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_byte;
      rresp_reg <= rd_hit ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ============================================================
  // outputs
  // ============================================================
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};
  assign s_axi_rresp = rresp_reg;
  assign mode_fault_disable_out = mode_fault_disable_reg;
endmodule

// [test/pio_far_model.sv]
// far side of port c: pin level from the block's drive or the outside source
`timescale 1ns/1ps
module pio_far_model (
  input wire logic [7:0] drive_val_in,
  input wire logic [7:0] drive_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] pin_out
);
  assign pin_out = (drive_en_in & drive_val_in) | (~drive_en_in & ext_val_in);
endmodule

// [test/pio_ports_chk.sv]
// concurrent checks on the parallel port block's timer pins, port b drive and read channel
`timescale 1ns/1ps
module pio_ports_chk (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] timer_port_in,
  input wire logic [7:0] timer_port_out,
  input wire logic [7:0] timer_port_oe_out,
  input wire logic [4:0] compare_force_in,
  input wire logic [4:0] compare_level_in,
  input wire logic pulse_accum_input_out,
  input wire logic [7:0] high_address_port_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  chk_pai_follows_pin: assert property (!$past(reset_in) |-> pulse_accum_input_out == $past(timer_port_in[7]))
    else $error("pulse input off line 7");
  chk_inputs_undriven: assert property (timer_port_oe_out[2:0] == 3'h0)
    else $error("input-only line driven");
  chk_line7_compare: assert property (!$past(reset_in) && $past(compare_force_in[4]) |->
    timer_port_oe_out[7] && timer_port_out[7] == $past(compare_level_in[4])) else $error("line 7 not compare");
  chk_line3_compare: assert property (!$past(reset_in) && $past(compare_force_in[0]) |->
    timer_port_oe_out[3] && timer_port_out[3] == $past(compare_level_in[0])) else $error("line 3 not compare");
  chk_port_b_drives: assert property (!$past(reset_in) && !$past(reset_in, 2) |-> high_address_port_oe_out == 8'hFF)
    else $error("port b not driven");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during read");
  chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
endmodule
bind pio_ports pio_ports_chk chk_i (.*);

// [test/tb.sv]
// self-checking bench for the parallel port block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b1, arv = 1'b0, rry = 1'b1, strobe_input_a = 1'b0, spi = 1'b0;
  logic awr, wr, bv, arr, rv, mfd;
  logic [15:0] awa = 16'h0, ara = 16'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] br, rr;
  logic [7:0] tin = 8'h0, cext = 8'h0, cpin, cout, coe, tout, toe, pb;
  logic [1:0] strap = pio_pkg::STRAP_SINGLE;
  logic [4:0] cf = 5'h0, cl = 5'h0;
  logic [5:0] din = 6'h0, doe, ae = 6'h0;
  int fails = 0, checked = 0, n;
  initial forever #2.5 clk = ~clk;
  pio_ports dut (.mclk_in(clk), .reset_in(rst), .mode_strap_in(strap), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .timer_port_in(tin), .timer_port_out(tout), .timer_port_oe_out(toe), .compare_force_in(cf),
    .compare_level_in(cl), .pulse_accum_input_out(), .capture_out(), .ext_addr_high_in(cext),
    .high_address_port_out(pb), .high_address_port_oe_out(), .address_data_port_in(cpin), .address_data_port_out(cout),
    .address_data_port_oe_out(coe), .ext_addr_data_in(cext), .ext_addr_data_drive_in(1'b0), .strobe_input_a_in(strobe_input_a),
    .serial_port_in(din), .serial_port_out(), .serial_port_oe_out(doe), .alt_enable_in(ae), .alt_level_in(ae),
    .alt_drive_in(ae), .spi_master_select_in(spi), .serial_pin_level_out(), .mode_fault_disable_out(mfd));
  pio_far_model far (.drive_val_in(cout), .drive_en_in(coe), .ext_val_in(cext), .pin_out(cpin));
  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_valid(input logic rsel);
    n = 0;
    do @(posedge clk); while ((rsel ? rv : bv) !== 1'b1 && ++n < 60);
    if (n == 60) begin
      fails++;
      close_out;
    end
  endtask
  task automatic wr_reg(input logic [13:0] idx, input logic [7:0] v);
    awa <= {idx, 2'b00};
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (((awv && !awr) || (wv && !wr)) && ++n < 60);
    if (n == 60) begin
      fails++;
      close_out;
    end
    wait_valid(1'b0);
    chk("bresp", br, pio_pkg::RESP_OKAY);
  endtask
  task automatic rd_chk(input string nm, input logic [13:0] idx, input logic [1:0] resp, input logic [7:0] v);
    ara <= {idx, 2'b00};
    arv <= 1'b1;
    n = 0;
    do @(posedge clk); while (arr !== 1'b1 && ++n < 60);
    if (n == 60) begin
      fails++;
      close_out;
    end
    arv <= 1'b0;
    wait_valid(1'b1);
    chk(nm, {rr, rd}, {resp, 24'h0, v});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("pac", pio_pkg::IDX_PULSE_ACCUM_CTRL, 2'h0, 8'h00);
    rd_chk("c_dir", pio_pkg::IDX_BUS_PORT_DIR, 2'h0, 8'h00);
    rd_chk("unmapped", 14'h0, pio_pkg::RESP_SLVERR, 8'h00);
    din <= 6'h2A;
    repeat (2) @(posedge clk);
    rd_chk("d_pins", pio_pkg::IDX_SERIAL_PORT, 2'h0, 8'h2A);
    wr_reg(pio_pkg::IDX_SERIAL_PORT_DIR, 8'h20);
    spi <= 1'b1;
    repeat (3) @(posedge clk);
    chk("d_mode", {mfd, doe}, 7'h60);
    wr_reg(pio_pkg::IDX_BUS_PORT_DIR, 8'hFF);
    wr_reg(pio_pkg::IDX_HIGH_ADDR_PORT, 8'h96);
    wr_reg(pio_pkg::IDX_ADDR_DATA_PORT, 8'h3C);
    repeat (2) @(posedge clk);
    chk("b_c_drive", {pb, coe, cout}, 24'h96FF3C);
    wr_reg(pio_pkg::IDX_BUS_PORT_DIR, 8'h00);
    cext <= 8'hA5;
    wr_reg(pio_pkg::IDX_PARALLEL_CONTROL, 8'h02);
    strobe_input_a <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("latch", pio_pkg::IDX_STROBE_LATCH, 2'h0, 8'hA5);
    rd_chk("flag_set", pio_pkg::IDX_PARALLEL_CONTROL, 2'h0, 8'h82);
    rd_chk("latch_again", pio_pkg::IDX_STROBE_LATCH, 2'h0, 8'hA5);
    rd_chk("flag_clear", pio_pkg::IDX_PARALLEL_CONTROL, 2'h0, 8'h02);
    wr_reg(pio_pkg::IDX_PULSE_ACCUM_CTRL, 8'h88);
    cf <= 5'h11;
    cl <= 5'h10;
    tin <= 8'h80;
    repeat (3) @(posedge clk);
    chk("a_drive", {toe[7], toe[3], tout[7], tout[3]}, 4'hE);
    strap <= pio_pkg::STRAP_EXPANDED;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("mode", pio_pkg::IDX_MODE_STATUS, 2'h0, 8'h02);
    chk("bus_pins", {pb, cout}, 16'hA5A5);
    close_out;
  end
endmodule
